// ### common/pwmcap_pkg.sv
// Shared constants, field positions and types of the four-channel PWM and capture group.
package pwmcap_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_PRESCALE = 8'h00;
  localparam logic [7:0] OFS_DIVSEL = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_CH_BASE = 8'h0c;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h0c;
  localparam logic [7:0] OFS_CH_CMP = 8'h04;
  localparam logic [7:0] OFS_CH_CNT = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h40;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h44;
  localparam logic [7:0] OFS_CAP_LO = 8'h50;
  localparam logic [7:0] OFS_CAP_HI = 8'h54;
  localparam logic [7:0] OFS_LATCH_BASE = 8'h58;
  localparam logic [7:0] OFS_LATCH_STRIDE = 8'h08;
  localparam logic [7:0] OFS_LATCH_FALL = 8'h04;
  localparam logic [7:0] OFS_CAP_IN_EN = 8'h78;
  localparam logic [7:0] OFS_PIN_OE = 8'h7c;

  // Reset value of every register.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Control word: one byte per channel, pair gap enables in channel 0's byte.
  localparam int CTL_EN = 0;
  localparam int CTL_INV = 2;
  localparam int CTL_MODE = 3;
  localparam int CTL_STRIDE = 8;
  localparam int CTL_DZEN = 4;

  // Capture control: one 16-bit half per channel.
  localparam int CC_INV = 0;
  localparam int CC_RIE = 1;
  localparam int CC_FIE = 2;
  localparam int CC_EN = 3;
  localparam int CC_EVT = 4;
  localparam int CC_RFL = 6;
  localparam int CC_FFL = 7;
  localparam int CC_HALF = 16;

  // Divider select field stride and the prescaler and gap field stride.
  localparam int DIV_STRIDE = 4;
  localparam int PS_STRIDE = 8;
  localparam int GAP_POS = 16;

  // Per-channel configuration carried from the control word.
  typedef struct packed {
    logic mode;
    logic inv;
    logic en;
  } pwmcap_chcfg_t;

  // Maps the 3-bit divider code to a power-of-two shift.
  function automatic logic [2:0] pwmcap_div_shift(input logic [2:0] code);
    logic [2:0] sh;
    sh = 3'h0;
    case (code)
      3'h4: sh = 3'h0;
      3'h0: sh = 3'h1;
      3'h1: sh = 3'h2;
      3'h2: sh = 3'h3;
      3'h3: sh = 3'h4;
      default: sh = 3'h0;
    endcase
    return sh;
  endfunction

endpackage

// ### design/pwmcap_chan.sv
// One 16-bit down-counting PWM timer with buffered period and compare values.
`timescale 1ns/10ps
module pwmcap_chan import pwmcap_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Count enable and configuration.
  input wire logic tick,
  input wire pwmcap_chcfg_t cfg,
  // Software writes and capture reload.
  input wire logic wr_per,
  input wire logic wr_cmp,
  input wire logic [15:0] wdata,
  input wire logic cap_reload,
  // State back to the register file.
  output logic [15:0] per_q,
  output logic [15:0] cmp_q,
  output logic [15:0] cnt_q,
  output logic raw,
  output logic zero
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic mode_q;          // Mode seen last cycle, to spot a change.
  logic [15:0] act_per_q; // Period in force for the running cycle.
  logic [15:0] act_cmp_q; // Compare in force for the running cycle.
  logic mode_chg;
  logic step;
  logic shot_end;

  assign mode_chg = cfg.mode != mode_q;
  assign step = cfg.en && tick;
  assign zero = step && cnt_q == 16'h0001 && !cap_reload;
  assign shot_end = zero && !cfg.mode;

  // Remembers the mode so that a change can wipe the settings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= cfg.mode;
    end
  end

  // Software copies; a mode change or a finished one-shot clears both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q <= RST_WORD[15:0];
      cmp_q <= RST_WORD[15:0];
    end else if (mode_chg) begin
      per_q <= 16'h0000;
      cmp_q <= 16'h0000;
    end else begin
      if (wr_per) begin
        per_q <= wdata;
      end else if (shot_end) begin
        per_q <= 16'h0000;
      end
      if (wr_cmp) begin
        cmp_q <= wdata;
      end else if (shot_end) begin
        cmp_q <= 16'h0000;
      end
    end
  end

  // Counter: values are taken over only at a period start, so writes never
  // disturb the cycle in progress.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= RST_WORD[15:0];
      act_per_q <= RST_WORD[15:0];
      act_cmp_q <= RST_WORD[15:0];
    end else if (cfg.en && cap_reload) begin
      cnt_q <= per_q;
    end else if (step) begin
      if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else if (per_q != 16'h0000) begin
        cnt_q <= per_q;
        act_per_q <= per_q;
        act_cmp_q <= cmp_q;
      end else begin
        act_per_q <= 16'h0000;
      end
    end
  end

  // High for compare+1 units at the tail of the count; disabling drops it at once.
  assign raw = cfg.en && act_per_q != 16'h0000 &&
               (act_cmp_q >= act_per_q || cnt_q <= act_cmp_q);

  a_hold_zero_per: assert property (step && !cap_reload && cnt_q == 16'h0000 && per_q == 16'h0000
    |=> cnt_q == 16'h0000) else $error("counter moved with zero period");
  a_auto_reload: assert property (step && !cap_reload && cnt_q == 16'h0000 && per_q != 16'h0000
    |=> cnt_q == $past(per_q) && act_cmp_q == $past(cmp_q)) else $error("no reload at zero");
  a_shot_clear: assert property (shot_end && !wr_per && !wr_cmp && !mode_chg
    |=> per_q == 16'h0000 && cmp_q == 16'h0000) else $error("one-shot left values");
  a_mode_wipe: assert property (mode_chg |=> per_q == 16'h0000 && cmp_q == 16'h0000)
    else $error("mode change kept values");
  a_stop_output: assert property (!cfg.en |-> !raw) else $error("output alive while off");
  a_duty_shape: assert property (raw && !$past(raw) && $past(step) && !$past(cap_reload) &&
    act_cmp_q < act_per_q |-> cnt_q == act_cmp_q) else $error("rise not at compare");

endmodule

// ### design/pwmcap_top.sv
// Four-channel PWM and capture group with an APB register slave.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
// How it works
// - Period is clock over prescale+1, divider, period+1.
// - Compare at or above period keeps output high.
// - Otherwise low period-compare, high compare+1 units.
// - New period waits for next period start.
// - Counter readback shows the live down-counter.
// - Mode bit 0 one-shot, 1 auto-reload.
// - Mode change clears period and compare.
// - One-shot end clears values, holds counter.
// - Nonzero period write restarts one-shot; compare first.
// - Auto-reload reloads period at zero.
// - Zero period stops the counter at zero.
// - Compare write waits for next period start.
// - Dead gap delays rising edges by programmed length.
// - Capture edges copy counter into rise/fall latches.
// - Separate rise and fall capture interrupt enables.
// - Capture interrupt reloads the channel counter.
// - One shared interrupt per channel, one per group.
// - Clearing enable stops output at once.
// - Counter reaching zero raises channel flag.
// - Prescaler divides by field+1; zero stops it.
// - Divider codes 100,000,001,010,011 give 1..16.
// - Gap enable makes even timer drive pair.
module pwmcap_top import pwmcap_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins.
  input wire logic [3:0] cap_in,
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_oe,
  // Interrupt requests.
  output logic [3:0] channel_irq,
  output logic group_one_irq
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Software-written registers.
  logic [31:0] prescale_word_q;       // Prescalers and gap lengths.
  logic [31:0] divider_select_word_q; // Divider codes.
  logic [31:0] channel_control_word_q; // Enable, inverter, mode, gap enables.
  logic [3:0] irq_enable_set_q;       // Period interrupt enables.
  logic [3:0] capture_input_enable_q; // Capture input enables.
  logic [3:0] pin_output_enable_q;    // Pin drive enables.
  logic [3:0] cap_ctl_q [4];          // Capture inverter, enables per channel.

  // Flags and captured state.
  logic [3:0] period_flag_q;
  logic [3:0] capture_event_flag_q;
  logic [3:0] rise_flag_q;
  logic [3:0] fall_flag_q;
  logic [15:0] rise_latch_value_q [4];
  logic [15:0] fall_latch_value_q [4];
  logic [3:0] cap_prev_q;             // Last sampled capture level.

  // Clock enables and channel state.
  logic [7:0] ps_q [2];
  logic [3:0] dv_q [4];
  logic [1:0] pair_tick;
  logic [3:0] ch_tick;
  logic [3:0] dv_lim [4];
  pwmcap_chcfg_t cfg [4];
  logic [15:0] per_v [4];
  logic [15:0] cmp_v [4];
  logic [15:0] counter_readback [4];
  logic [3:0] raw;
  logic [3:0] zero;

  // Capture edges.
  logic [3:0] cap_lvl;
  logic [3:0] rise_evt;
  logic [3:0] fall_evt;
  logic [3:0] cap_irq_set;

  // Gap generators, one lane per pin.
  logic [3:0] lane_src;
  logic [3:0] lane_gap;
  logic [7:0] dz_cnt_q [4];
  logic [3:0] dz_out_q;
  logic [1:0] pair_dead_gap_enable;
  logic [3:0] pwm_out_q;

  // Bus decode.
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic [3:0] wr_per;
  logic [3:0] wr_cmp;
  logic [31:0] prdata_q;

  // The slave never waits: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;

  // Address decode and read mux.
  always_comb begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    wr_per = 4'h0;
    wr_cmp = 4'h0;
    case (paddr)
      OFS_PRESCALE: rd = prescale_word_q;
      OFS_DIVSEL: rd = divider_select_word_q;
      OFS_CONTROL: rd = channel_control_word_q;
      OFS_IRQ_EN: rd = {28'h0, irq_enable_set_q};
      OFS_IRQ_FLAG: rd = {28'h0, period_flag_q};
      OFS_CAP_IN_EN: rd = {28'h0, capture_input_enable_q};
      OFS_PIN_OE: rd = {28'h0, pin_output_enable_q};
      OFS_CAP_LO, OFS_CAP_HI: rd = 32'h0;
      default: hit = 1'b0;
    endcase
    for (int c = 0; c < 4; c++) begin
      if (paddr == 8'(OFS_CH_BASE + c * OFS_CH_STRIDE)) begin
        hit = 1'b1;
        rd = {16'h0, per_v[c]};
        wr_per[c] = wr;
      end
      if (paddr == 8'(OFS_CH_BASE + c * OFS_CH_STRIDE + OFS_CH_CMP)) begin
        hit = 1'b1;
        rd = {16'h0, cmp_v[c]};
        wr_cmp[c] = wr;
      end
      if (paddr == 8'(OFS_CH_BASE + c * OFS_CH_STRIDE + OFS_CH_CNT)) begin
        hit = 1'b1;
        rd = {16'h0, counter_readback[c]};
      end
      if (paddr == 8'(OFS_LATCH_BASE + c * OFS_LATCH_STRIDE)) begin
        hit = 1'b1;
        rd = {16'h0, rise_latch_value_q[c]};
      end
      if (paddr == 8'(OFS_LATCH_BASE + c * OFS_LATCH_STRIDE + OFS_LATCH_FALL)) begin
        hit = 1'b1;
        rd = {16'h0, fall_latch_value_q[c]};
      end
      if (paddr == (c < 2 ? OFS_CAP_LO : OFS_CAP_HI)) begin
        rd[CC_HALF * (c % 2) +: 8] = {fall_flag_q[c], rise_flag_q[c], 1'b0,
                                      capture_event_flag_q[c], cap_ctl_q[c]};
      end
    end
  end

  // Read data is sampled in the setup cycle and held through the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd;
    end
  end

  // Plain configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_word_q <= RST_WORD;
      divider_select_word_q <= RST_WORD;
      channel_control_word_q <= RST_WORD;
      irq_enable_set_q <= RST_WORD[3:0];
      capture_input_enable_q <= RST_WORD[3:0];
      pin_output_enable_q <= RST_WORD[3:0];
    end else if (wr) begin
      case (paddr)
        OFS_PRESCALE: prescale_word_q <= pwdata;
        OFS_DIVSEL: divider_select_word_q <= pwdata & 32'h0000_7777;
        OFS_CONTROL: channel_control_word_q <= pwdata & 32'h0d0d_0d3d;
        OFS_IRQ_EN: irq_enable_set_q <= pwdata[3:0];
        OFS_CAP_IN_EN: capture_input_enable_q <= pwdata[3:0];
        OFS_PIN_OE: pin_output_enable_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Pair prescalers: a zero field parks the counter and stops every tick after it.
  for (genvar p = 0; p < 2; p++) begin : g_pair
    logic [7:0] cp;
    assign cp = prescale_word_q[PS_STRIDE * p +: 8];
    assign pair_tick[p] = cp != 8'h00 && ps_q[p] >= cp;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ps_q[p] <= 8'h00;
      end else if (cp == 8'h00 || ps_q[p] >= cp) begin
        ps_q[p] <= 8'h00;
      end else begin
        ps_q[p] <= ps_q[p] + 8'h01;
      end
    end
  end

  // Channel dividers and timers; period is prescale+1 times divider times period+1.
  for (genvar c = 0; c < 4; c++) begin : g_ch
    assign dv_lim[c] = 4'((5'h01 << pwmcap_div_shift(
                       divider_select_word_q[DIV_STRIDE * c +: 3])) - 5'h01);
    assign ch_tick[c] = pair_tick[c / 2] && dv_q[c] >= dv_lim[c];
    assign cfg[c] = '{mode: channel_control_word_q[CTL_STRIDE * c + CTL_MODE],
                      inv: channel_control_word_q[CTL_STRIDE * c + CTL_INV],
                      en: channel_control_word_q[CTL_STRIDE * c + CTL_EN]};
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dv_q[c] <= 4'h0;
      end else if (pair_tick[c / 2]) begin
        dv_q[c] <= ch_tick[c] ? 4'h0 : dv_q[c] + 4'h1;
      end
    end
    pwmcap_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .tick(ch_tick[c]),
      .cfg(cfg[c]),
      .wr_per(wr_per[c]),
      .wr_cmp(wr_cmp[c]),
      .wdata(pwdata[15:0]),
      .cap_reload(cap_irq_set[c]),
      .per_q(per_v[c]),
      .cmp_q(cmp_v[c]),
      .cnt_q(counter_readback[c]),
      .raw(raw[c]),
      .zero(zero[c])
    );
  end

  // Capture edge detection on the optionally inverted input level.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      cap_lvl[c] = cap_in[c] ^ cap_ctl_q[c][CC_INV];
      rise_evt[c] = capture_input_enable_q[c] && cap_ctl_q[c][CC_EN] &&
                    cap_lvl[c] && !cap_prev_q[c];
      fall_evt[c] = capture_input_enable_q[c] && cap_ctl_q[c][CC_EN] &&
                    !cap_lvl[c] && cap_prev_q[c];
      cap_irq_set[c] = (rise_evt[c] && cap_ctl_q[c][CC_RIE]) ||
                       (fall_evt[c] && cap_ctl_q[c][CC_FIE]);
    end
  end

  // Capture latches and their level history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev_q <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        rise_latch_value_q[c] <= RST_WORD[15:0];
        fall_latch_value_q[c] <= RST_WORD[15:0];
      end
    end else begin
      cap_prev_q <= cap_lvl;
      for (int c = 0; c < 4; c++) begin
        if (rise_evt[c]) begin
          rise_latch_value_q[c] <= counter_readback[c];
        end
        if (fall_evt[c]) begin
          fall_latch_value_q[c] <= counter_readback[c];
        end
      end
    end
  end

  // Capture control and flags; a flag set in the clearing cycle survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_flag_q <= 4'h0;
      fall_flag_q <= 4'h0;
      capture_event_flag_q <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        cap_ctl_q[c] <= 4'h0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (wr && paddr == (c < 2 ? OFS_CAP_LO : OFS_CAP_HI)) begin
          cap_ctl_q[c] <= pwdata[CC_HALF * (c % 2) +: 4];
          rise_flag_q[c] <= rise_evt[c] || (rise_flag_q[c] &&
                            !pwdata[CC_HALF * (c % 2) + CC_RFL]);
          fall_flag_q[c] <= fall_evt[c] || (fall_flag_q[c] &&
                            !pwdata[CC_HALF * (c % 2) + CC_FFL]);
          capture_event_flag_q[c] <= cap_irq_set[c] || (capture_event_flag_q[c] &&
                                     !pwdata[CC_HALF * (c % 2) + CC_EVT]);
        end else begin
          rise_flag_q[c] <= rise_flag_q[c] || rise_evt[c];
          fall_flag_q[c] <= fall_flag_q[c] || fall_evt[c];
          capture_event_flag_q[c] <= capture_event_flag_q[c] || cap_irq_set[c];
        end
      end
    end
  end

  // Period flags: set at zero, cleared by writing one; the set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_flag_q <= 4'h0;
    end else if (wr && paddr == OFS_IRQ_FLAG) begin
      period_flag_q <= zero | (period_flag_q & ~pwdata[3:0]);
    end else begin
      period_flag_q <= period_flag_q | zero;
    end
  end

  // One request per channel shared by PWM and capture, merged for the group.
  assign channel_irq = (period_flag_q & irq_enable_set_q) | capture_event_flag_q;
  assign group_one_irq = |channel_irq;

  // Lane sources: with the gap enabled the even timer drives both pins.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pair_dead_gap_enable[p] = channel_control_word_q[CTL_DZEN + p];
      lane_src[2 * p] = raw[2 * p];
      lane_src[2 * p + 1] = pair_dead_gap_enable[p] ?
        (cfg[2 * p].en && !raw[2 * p]) : raw[2 * p + 1];
      lane_gap[2 * p] = pair_dead_gap_enable[p];
      lane_gap[2 * p + 1] = pair_dead_gap_enable[p];
    end
  end

  // Gap timers hold each rising edge back by the pair's gap length in even-channel ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dz_out_q <= 4'h0;
      for (int l = 0; l < 4; l++) begin
        dz_cnt_q[l] <= 8'h00;
      end
    end else begin
      for (int l = 0; l < 4; l++) begin
        if (!lane_src[l]) begin
          dz_out_q[l] <= 1'b0;
          dz_cnt_q[l] <= prescale_word_q[GAP_POS + PS_STRIDE * (l / 2) +: 8];
        end else if (dz_cnt_q[l] == 8'h00) begin
          dz_out_q[l] <= 1'b1;
        end else if (ch_tick[(l / 2) * 2]) begin
          dz_cnt_q[l] <= dz_cnt_q[l] - 8'h01;
        end
      end
    end
  end

  // Pin data is registered; the output inverter acts last.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out_q <= 4'h0;
    end else begin
      for (int l = 0; l < 4; l++) begin
        pwm_out_q[l] <= (lane_gap[l] ? dz_out_q[l] : lane_src[l]) ^ cfg[l].inv;
      end
    end
  end

  assign pwm_out = pwm_out_q;
  assign pwm_oe = pin_output_enable_q;

  sequence s_rise1;
    rise_evt[1] ##1 rise_latch_value_q[1] == $past(counter_readback[1]);
  endsequence
  sequence s_tick_gap;
    !pair_tick[0] ##1 pair_tick[0];
  endsequence

  a_rise_latch: assert property (rise_evt[1] |-> s_rise1)
    else $error("rise latch missed counter");
  a_fall_latch: assert property (fall_evt[1] |=>
    fall_latch_value_q[1] == $past(counter_readback[1])) else $error("fall latch wrong");
  a_cap_reload: assert property (cap_irq_set[1] && cfg[1].en |=>
    counter_readback[1] == $past(per_v[1]) && capture_event_flag_q[1])
    else $error("capture did not reload");
  a_prescale_stop: assert property (prescale_word_q[7:0] == 8'h00 |-> !pair_tick[0])
    else $error("prescaler ran at zero");
  a_prescale_rate: assert property (pair_tick[0] && prescale_word_q[7:0] == 8'h01 &&
    $stable(prescale_word_q) |=> s_tick_gap) else $error("prescale by two broken");
  a_zero_flag: assert property (zero[0] |=> period_flag_q[0])
    else $error("zero did not flag");
  a_irq_share: assert property (capture_event_flag_q[1] |-> channel_irq[1] && group_one_irq)
    else $error("capture request not merged");
  a_apb_error: assert property (psel && penable && paddr == 8'h3c |-> pslverr)
    else $error("unmapped access not refused");

endmodule

// ### testbench/pwmcap_sig_src.sv
// Model of the external signals that the capture inputs measure.
`timescale 1ns/10ps
module pwmcap_sig_src (
  // Clock.
  input wire logic pclk,
  // Measured signals toward the capture inputs.
  output logic [3:0] cap_in
);
  // The measured lines idle low, as a pulled-down source would.
  initial cap_in = 4'h0;

  // One high pulse on a lane; edges land just after a rising edge.
  task automatic pulse(input int lane, input int hi_cycles);
    @(posedge pclk);
    cap_in[lane] <= 1'b1;
    repeat (hi_cycles) @(posedge pclk);
    cap_in[lane] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// ### testbench/pwmcap_tb_top.sv
// Self-checking bench of the PWM and capture group.
`timescale 1ns/10ps
module pwmcap_tb_top import pwmcap_pkg::*;;
  // One row: divider code, compare, period, period and high time in pclk, rises.
  typedef struct {logic [2:0] code; logic [15:0] cmp; logic [15:0] per; int t; int hi; int ri;}
    pwmcap_row_t;
  pwmcap_row_t rows [6] = '{'{3'h4, 16'h0002, 16'h0005, 12, 6, 1},
    '{3'h0, 16'h0000, 16'h0003, 16, 4, 1}, '{3'h1, 16'h0007, 16'h0007, 64, 64, 0},
    '{3'h2, 16'h0001, 16'h0002, 48, 32, 1}, '{3'h3, 16'h0000, 16'h0001, 64, 32, 1},
    '{3'h4, 16'h0009, 16'h0003, 8, 8, 0}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, group_one_irq, e;
  logic [3:0] cap_in, pwm_out, pwm_oe, channel_irq;
  int errors = 0;
  int n_checks = 0;
  int hi, ri;
  // 50 MHz clock.
  always #10 pclk = ~pclk;

  pwmcap_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .channel_irq(channel_irq), .group_one_irq(group_one_irq));
  pwmcap_sig_src i_src (.pclk(pclk), .cap_in(cap_in));

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h", $time, m, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      errors++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Counts high cycles and rising edges of one pin over a window.
  task automatic meas(input int b, input int n);
    logic p;
    hi = 0;
    ri = 0;
    p = pwm_out[b];
    repeat (n) begin
      @(posedge pclk);
      if (pwm_out[b] === 1'b1) hi++;
      if (pwm_out[b] === 1'b1 && p === 1'b0) ri++;
      p = pwm_out[b];
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      wr(OFS_CONTROL, 32'h0000_0008);
      wr(OFS_DIVSEL, {29'h0, rows[i].code});
      wr(OFS_PRESCALE, 32'h0000_0001);
      wr(OFS_CH_BASE + OFS_CH_CMP, {16'h0, rows[i].cmp});
      wr(OFS_CH_BASE, {16'h0, rows[i].per});
      wr(OFS_PIN_OE, 32'h0000_0001);
      wr(OFS_CONTROL, 32'h0000_0009);
      repeat (3 * rows[i].t) @(posedge pclk);
      meas(0, 2 * rows[i].t);
      check(32'(hi), 32'(2 * rows[i].hi), "high time");
      check(32'(ri), 32'(2 * rows[i].ri), "periods");
    end
    // A reset in mid-run must bring every register and pin back to zero.
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    check({24'h0, pwm_oe, pwm_out}, 32'h0, "pins in reset");
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 8'h80; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check(r, RST_WORD, "reset value");
    end
    apb(1'b0, 8'h90, 32'h0);
    check({31'h0, e}, 32'h1, "unmapped");
    // Mode change clears the period.
    wr(OFS_CONTROL, 32'h0000_0008);
    wr(OFS_CH_BASE, 32'h0000_0005);
    wr(OFS_CONTROL, 32'h0000_0000);
    apb(1'b0, OFS_CH_BASE, 32'h0);
    check(r, 32'h0, "period kept");
    // One-shot run ends with a cleared period, a held counter and a flag.
    wr(OFS_PRESCALE, 32'h0000_0001);
    wr(OFS_IRQ_EN, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_0001);
    wr(OFS_CH_BASE + OFS_CH_CMP, 32'h0000_0001);
    wr(OFS_CH_BASE, 32'h0000_0003);
    for (int n = 0; n < 400 && channel_irq[0] !== 1'b1; n++) @(posedge pclk);
    check({31'h0, group_one_irq}, 32'h1, "group irq");
    if (channel_irq[0] !== 1'b1) end_of_test();
    apb(1'b0, OFS_CH_BASE, 32'h0);
    check(r, 32'h0, "one-shot period");
    apb(1'b0, OFS_CH_BASE + OFS_CH_CNT, 32'h0);
    check(r, 32'h0, "counter held");
    wr(OFS_IRQ_FLAG, 32'h0000_0001);
    check({31'h0, channel_irq[0]}, 32'h0, "flag clear");
    // Disabling stops an always-high output at once.
    wr(OFS_CONTROL, 32'h0000_0008);
    wr(OFS_CH_BASE + OFS_CH_CMP, 32'h0000_0007);
    wr(OFS_CH_BASE, 32'h0000_0003);
    wr(OFS_CONTROL, 32'h0000_0009);
    repeat (40) @(posedge pclk);
    check({31'h0, pwm_out[0]}, 32'h1, "always high");
    wr(OFS_CONTROL, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    check({31'h0, pwm_out[0]}, 32'h0, "stop");
    // Complementary pair with a dead gap: never both high.
    wr(OFS_PRESCALE, 32'h0001_0001);
    wr(OFS_CONTROL, 32'h0000_0018);
    wr(OFS_CH_BASE + OFS_CH_CMP, 32'h0000_0003);
    wr(OFS_CH_BASE, 32'h0000_0007);
    wr(OFS_PIN_OE, 32'h0000_0003);
    check({28'h0, pwm_oe}, 32'h3, "pin enables");
    wr(OFS_CONTROL, 32'h0000_0019);
    repeat (60) @(posedge pclk);
    hi = 0;
    ri = 0;
    repeat (64) begin
      @(posedge pclk);
      if (pwm_out[0] === 1'b1 && pwm_out[1] === 1'b1) hi++;
      if (pwm_out[1] === 1'b1) ri++;
    end
    check(32'(hi), 32'h0, "overlap");
    check({31'h0, ri > 0 && ri < 32}, 32'h1, "odd lane");
    // Orderly stop: zero period, let the counter drain, then disable.
    wr(OFS_CH_BASE, 32'h0000_0000);
    apb(1'b0, OFS_CH_BASE + OFS_CH_CNT, 32'h0);
    for (int n = 0; n < 64 && r !== 32'h0; n++) apb(1'b0, OFS_CH_BASE + OFS_CH_CNT, 32'h0);
    check(r, 32'h0, "drained");
    if (r !== 32'h0) end_of_test();
    // Capture on channel 1; the rising edge reloads the counter.
    wr(OFS_CONTROL, 32'h0000_0900);
    wr(OFS_CH_BASE + OFS_CH_STRIDE, 32'h0000_00c8);
    wr(OFS_PIN_OE, 32'h0000_0000);
    wr(OFS_CAP_IN_EN, 32'h0000_0002);
    wr(OFS_CAP_LO, 32'h000e_0000);
    repeat (10) @(posedge pclk);
    i_src.pulse(1, 40);
    check({31'h0, channel_irq[1]}, 32'h1, "capture irq");
    apb(1'b0, OFS_LATCH_BASE + OFS_LATCH_STRIDE + OFS_LATCH_FALL, 32'h0);
    check({31'h0, r >= 188 && r <= 192}, 32'h1, "fall latch");
    wr(OFS_CAP_LO, 32'h00d8_0000);
    check({31'h0, channel_irq[1]}, 32'h0, "capture clear");
    i_src.pulse(1, 40);
    check({31'h0, channel_irq[1]}, 32'h0, "masked edge");
    end_of_test();
  end
endmodule
